// *** pis_core.sv ***
// Interrupt flags, fixed-priority arbiter and vector generation
//
// Summary of operation
// - Trap is unmaskable, stacks PC not PC-1
// - Upper index register never stacked on entry
// - Global mask blocks all but trap
// - Fixed priority, lower level number wins
// - Each group fetches own vector pair
// - Low request pin latches external request
// - Break point forces trap instruction
// - Clock loss flag while monitor on
// - Timer wrap to zero sets overflow flag
// - Capture or compare sets channel flag
// - SPI receive transfer sets receive-full flag
// - SPI transmit transfer sets transmit-empty flag
// - Mode fault per slave/master select rules
// - SPI unread byte overwritten sets overflow
// - UART handoff to shifter sets tx-empty
// - UART both empty, no break: tx-done
// - UART receive handoff sets receive-full
// - UART ten/eleven ones set idle flag
// - UART overrun feeds shared error request
// - UART noise feeds shared error request
// - UART zero stop bit: framing error
// - UART parity failure feeds error request
// - Arbitrate after instruction, mask clear only
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"

module pis_core (
    input wire logic clk,
    input wire logic rstn,
    // Core handshake
    input wire logic instr_done,
    input wire logic global_mask,
    input wire logic soft_trap_instr,
    input wire logic break_hit,
    input wire pis_pkg::pis_addr_t cur_pc,
    output logic entry_req,
    output pis_pkg::pis_addr_t vector_addr,
    output pis_pkg::pis_addr_t stacked_pc,
    output logic stack_upper_index,
    output logic force_trap,
    output pis_pkg::pis_level_t entry_level,
    // External pin, active low
    input wire logic ext_req_n,
    input wire logic ext_request_mask,
    input wire logic ext_clear,
    // Clock monitor
    input wire logic clock_monitor_on,
    input wire logic sel_clock_active,
    input wire logic clock_loss_int_en,
    input wire logic clock_loss_clear,
    // Timers: index 0 is unit one, 1 is unit two
    input wire logic [1:0] tim_wrap,
    input wire logic [15:0] tim_cnt_next,
    input wire logic [1:0] counter_wrap_int_en,
    input wire logic [1:0] counter_wrap_clear,
    input wire logic [3:0] chan_event,
    input wire logic [3:0] chan_event_int_en,
    input wire logic [3:0] chan_event_clear,
    // SPI
    input wire logic spi_rx_xfer,
    input wire logic spi_tx_xfer,
    input wire logic spi_is_master,
    input wire logic spi_busy,
    input wire logic spi_sel_n,
    input wire logic spi_mode_fault_check_en,
    input wire logic spi_rx_unread,
    input wire logic spi_rx_int_en,
    input wire logic spi_tx_int_en,
    input wire logic spi_error_int_en,
    input wire logic [3:0] spi_clear,
    // UART
    input wire logic uart_tx_handoff,
    input wire logic uart_tx_shift_empty,
    input wire logic uart_tx_data_empty,
    input wire logic uart_break_idle_gen,
    input wire logic uart_rx_handoff,
    input wire logic uart_rx_unread,
    input wire logic uart_rx_bit_valid,
    input wire logic uart_rx_bit,
    input wire logic uart_idle_long,
    input wire logic uart_noise_seen,
    input wire logic uart_stop_sample,
    input wire logic uart_parity_bad,
    input wire logic uart_tx_empty_en,
    input wire logic uart_tx_done_en,
    input wire logic uart_rx_full_en,
    input wire logic uart_idle_int_en,
    input wire logic uart_overrun_en,
    input wire logic uart_noise_en,
    input wire logic uart_framing_int_en,
    input wire logic uart_parity_int_en,
    input wire logic [7:0] uart_clear,
    // Other groups, flags already gated
    input wire logic [2:0] other_req,
    // Status
    output logic [15:0] pending_source_bit,
    output logic ext_request_flag,
    output logic clock_loss_flag,
    output logic [1:0] counter_wrap_flag,
    output logic [3:0] chan_event_flag,
    output logic spi_rx_full_flag,
    output logic spi_tx_empty_flag,
    output logic spi_mode_fault_flag,
    output logic spi_overflow_flag,
    output logic [7:0] uart_flags
);
    import pis_pkg::*;

    logic [2:0] ext_sync_q;
    logic [2:0] sel_sync_q;
    logic [2:0] clk_act_q;
    logic ext_lvl_q;
    logic sel_lvl_q;
    logic clk_lvl_q;
    logic [3:0] ones_q;
    logic [15:0] grp_req;
    pis_state_e state_q;
    logic [4:0] win_idx;
    logic win_any;
    logic [4:0] entry_idx_q;
    logic trap_q;
    logic [15:0] pc_q;
    logic ext_fall;
    logic sel_rise;
    logic sel_fall;
    logic clk_stop;
    logic [7:0] uart_set;

    // Three-stage synchronisers; change accepted once stages 2 and 3 agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync_q <= 3'h7;
            sel_sync_q <= 3'h7;
            clk_act_q <= 3'h7;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_req_n};
            sel_sync_q <= {sel_sync_q[1:0], spi_sel_n};
            clk_act_q <= {clk_act_q[1:0], sel_clock_active};
        end
    end

    // Filtered levels, updated only when stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_lvl_q <= 1'b1;
            sel_lvl_q <= 1'b1;
            clk_lvl_q <= 1'b1;
        end else begin
            if (ext_sync_q[1] == ext_sync_q[2]) ext_lvl_q <= ext_sync_q[2];
            if (sel_sync_q[1] == sel_sync_q[2]) sel_lvl_q <= sel_sync_q[2];
            if (clk_act_q[1] == clk_act_q[2]) clk_lvl_q <= clk_act_q[2];
        end
    end

    assign ext_fall = ext_lvl_q && (ext_sync_q[1] == ext_sync_q[2]) && !ext_sync_q[2];
    assign sel_rise = !sel_lvl_q && (sel_sync_q[1] == sel_sync_q[2]) && sel_sync_q[2];
    assign sel_fall = sel_lvl_q && (sel_sync_q[1] == sel_sync_q[2]) && !sel_sync_q[2];
    assign clk_stop = clk_lvl_q && (clk_act_q[1] == clk_act_q[2]) && !clk_act_q[2];

    // Low pin latches request; set beats clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ext_request_flag <= 1'b0;
        else if (ext_fall || (!ext_lvl_q && ext_sync_q[2] == 1'b0))
            ext_request_flag <= 1'b1;
        else if (ext_clear) ext_request_flag <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) clock_loss_flag <= 1'b0;
        else if (clock_monitor_on && clk_stop) clock_loss_flag <= 1'b1;
        else if (clock_loss_clear) clock_loss_flag <= 1'b0;
    end

    // Per-timer and per-channel flags
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wrap
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) counter_wrap_flag[gi] <= 1'b0;
                else if (tim_wrap[gi] && tim_cnt_next == `PIS_CNT_ZERO)
                    counter_wrap_flag[gi] <= 1'b1;
                else if (counter_wrap_clear[gi]) counter_wrap_flag[gi] <= 1'b0;
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_chan
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) chan_event_flag[gi] <= 1'b0;
                else if (chan_event[gi]) chan_event_flag[gi] <= 1'b1;
                else if (chan_event_clear[gi]) chan_event_flag[gi] <= 1'b0;
            end
        end
    endgenerate

    // SPI flags; set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spi_rx_full_flag <= 1'b0;
            spi_tx_empty_flag <= 1'b0;
            spi_mode_fault_flag <= 1'b0;
            spi_overflow_flag <= 1'b0;
        end else begin
            if (spi_rx_xfer) spi_rx_full_flag <= 1'b1;
            else if (spi_clear[0]) spi_rx_full_flag <= 1'b0;
            if (spi_tx_xfer) spi_tx_empty_flag <= 1'b1;
            else if (spi_clear[1]) spi_tx_empty_flag <= 1'b0;
            // Slave rise mid-transfer, master any fall
            if (spi_mode_fault_check_en &&
                ((!spi_is_master && spi_busy && sel_rise) || (spi_is_master && sel_fall)))
                spi_mode_fault_flag <= 1'b1;
            else if (spi_clear[2]) spi_mode_fault_flag <= 1'b0;
            if (spi_rx_xfer && spi_rx_unread) spi_overflow_flag <= 1'b1;
            else if (spi_clear[3]) spi_overflow_flag <= 1'b0;
        end
    end

    // Count consecutive ones on the receive line
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ones_q <= 4'h0;
        else if (uart_rx_bit_valid) begin
            if (!uart_rx_bit) ones_q <= 4'h0;
            else if (ones_q != `PIS_IDLE_ONES_LONG) ones_q <= ones_q + 4'h1;
        end
    end

    // UART set terms: txe, done, rxf, idle, overrun, noise, frame, parity
    always_comb begin
        uart_set[0] = uart_tx_handoff;
        uart_set[1] = uart_tx_shift_empty && uart_tx_data_empty && !uart_break_idle_gen
                      && !uart_flags[1];
        uart_set[2] = uart_rx_handoff;
        // Ten or eleven ones, per frame length
        uart_set[3] = uart_rx_bit_valid && uart_rx_bit &&
                      (ones_q + 4'h1 == (uart_idle_long ? `PIS_IDLE_ONES_LONG
                                                        : `PIS_IDLE_ONES_SHORT));
        uart_set[4] = uart_rx_handoff && uart_rx_unread;
        uart_set[5] = uart_noise_seen;
        uart_set[6] = uart_stop_sample && !uart_rx_bit;
        uart_set[7] = uart_parity_bad;
    end

    generate
        for (gi = 0; gi < 8; gi++) begin : g_uart
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) uart_flags[gi] <= 1'b0;
                else if (uart_set[gi]) uart_flags[gi] <= 1'b1;
                else if (uart_clear[gi]) uart_flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // Group requests follow flag and enable; several flags share a group
    always_comb begin
        grp_req[0] = ext_request_flag && !ext_request_mask;
        grp_req[1] = clock_loss_flag && clock_loss_int_en;
        grp_req[2] = chan_event_flag[0] && chan_event_int_en[0];
        grp_req[3] = chan_event_flag[1] && chan_event_int_en[1];
        grp_req[4] = counter_wrap_flag[0] && counter_wrap_int_en[0];
        grp_req[5] = chan_event_flag[2] && chan_event_int_en[2];
        grp_req[6] = chan_event_flag[3] && chan_event_int_en[3];
        grp_req[7] = counter_wrap_flag[1] && counter_wrap_int_en[1];
        grp_req[8] = (spi_rx_full_flag && spi_rx_int_en) ||
                     ((spi_overflow_flag || spi_mode_fault_flag) && spi_error_int_en);
        grp_req[9] = spi_tx_empty_flag && spi_tx_int_en;
        grp_req[10] = (uart_flags[4] && uart_overrun_en) || (uart_flags[5] && uart_noise_en) ||
                      (uart_flags[6] && uart_framing_int_en) ||
                      (uart_flags[7] && uart_parity_int_en);
        grp_req[11] = (uart_flags[2] && uart_rx_full_en) || (uart_flags[3] && uart_idle_int_en);
        grp_req[12] = (uart_flags[0] && uart_tx_empty_en) || (uart_flags[1] && uart_tx_done_en);
        grp_req[15:13] = other_req;
    end

    assign pending_source_bit = grp_req;

    // Lowest level number wins; scan from the top, last hit kept
    always_comb begin
        win_any = 1'b0;
        win_idx = 5'h00;
        for (int i = `PIS_NUM_SRC - 1; i >= 0; i--) begin
            if (grp_req[i]) begin
                win_any = 1'b1;
                win_idx = 5'(i);
            end
        end
    end

    // Decision at instruction end, trap first, mask gates hardware
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= PIS_ST_RUN;
            trap_q <= 1'b0;
            entry_idx_q <= 5'h00;
            pc_q <= 16'h0000;
        end else begin
            unique case (state_q)
                PIS_ST_RUN: begin
                    if (instr_done) begin
                        // Trap ignores the mask, stacks PC
                        if (soft_trap_instr || break_hit) begin
                            state_q <= PIS_ST_ENTRY;
                            trap_q <= 1'b1;
                            pc_q <= cur_pc;
                        end else if (win_any && !global_mask) begin
                            state_q <= PIS_ST_ENTRY;
                            trap_q <= 1'b0;
                            entry_idx_q <= win_idx;
                            pc_q <= cur_pc - `PIS_MSG_PC_ADJ;
                        end
                    end
                end
                PIS_ST_ENTRY: begin
                    state_q <= PIS_ST_RUN;
                end
            endcase
        end
    end

    // Vector pair per group, counting down two bytes per level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vector_addr <= `PIS_VEC_RESET;
            entry_level <= 5'h00;
        end else if (state_q == PIS_ST_RUN && instr_done) begin
            if (soft_trap_instr || break_hit) begin
                vector_addr <= `PIS_VEC_TRAP;
                entry_level <= 5'h00;
            end else if (win_any && !global_mask) begin
                vector_addr <= `PIS_VEC_TRAP - `PIS_VEC_STEP * {11'h000, win_idx + 5'h01};
                entry_level <= win_idx + 5'h01;
            end
        end
    end

    assign entry_req = (state_q == PIS_ST_ENTRY);
    assign stacked_pc = pc_q;
    // Upper index register left off the stack
    assign stack_upper_index = 1'b0;
    // Break point turns into a trap
    assign force_trap = break_hit;

endmodule : pis_core
`default_nettype wire

// *** pis_params.svh ***
// Constants for the prioritized interrupt source block
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH

`define PIS_NUM_SRC 16
`define PIS_VEC_RESET 16'hFFFE
`define PIS_VEC_TRAP 16'hFFFC
`define PIS_VEC_LOWEST 16'hFFDC
`define PIS_VEC_STEP 16'h0002
`define PIS_MSG_PC_ADJ 16'h0001
`define PIS_CNT_ZERO 16'h0000
`define PIS_IDLE_ONES_SHORT 4'hA
`define PIS_IDLE_ONES_LONG 4'hB

`endif

// *** pis_pkg.sv ***
// Types shared by the prioritized interrupt source block
`default_nettype none
package pis_pkg;
    typedef logic [15:0] pis_addr_t;
    typedef logic [4:0] pis_level_t;
    typedef enum logic [1:0] {
        PIS_ST_RUN,
        PIS_ST_ENTRY
    } pis_state_e;
endpackage : pis_pkg
`default_nettype wire

// *** pis_core_sva.sv ***
// Concurrent checks on the interrupt source block ports
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"
module pis_core_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_done,
    input wire logic global_mask,
    input wire logic soft_trap_instr,
    input wire logic break_hit,
    input wire pis_pkg::pis_addr_t cur_pc,
    input wire logic entry_req,
    input wire pis_pkg::pis_addr_t vector_addr,
    input wire pis_pkg::pis_addr_t stacked_pc,
    input wire logic stack_upper_index,
    input wire logic force_trap,
    input wire pis_pkg::pis_level_t entry_level,
    input wire logic ext_req_n,
    input wire logic [1:0] tim_wrap,
    input wire logic [15:0] tim_cnt_next,
    input wire logic [3:0] chan_event_int_en,
    input wire logic spi_rx_xfer,
    input wire logic uart_tx_handoff,
    input wire logic [15:0] pending_source_bit,
    input wire logic ext_request_flag,
    input wire logic [1:0] counter_wrap_flag,
    input wire logic [3:0] chan_event_flag,
    input wire logic spi_rx_full_flag,
    input wire logic [7:0] uart_flags
);
    import pis_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Lowest pending bit wins; no pending gives level zero
    function automatic pis_level_t win_lvl(input logic [15:0] p);
        win_lvl = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (p[i]) begin
                win_lvl = pis_level_t'(i + 1);
            end
        end
    endfunction : win_lvl

    // Entry behaviour
    a_trap_entry: assert property (
        instr_done && soft_trap_instr && !entry_req |=> entry_req && entry_level == 5'h00
        && vector_addr == `PIS_VEC_TRAP && stacked_pc == $past(cur_pc))
        else $error("trap entry wrong");
    a_upper_unstacked: assert property (stack_upper_index == 1'h0)
        else $error("upper index stacked");
    a_mask_blocks: assert property (
        instr_done && global_mask && !soft_trap_instr && !break_hit && !entry_req |=> !entry_req)
        else $error("masked entry taken");
    a_hw_entry: assert property (
        instr_done && !global_mask && !soft_trap_instr && !break_hit && !entry_req
        && pending_source_bit != 16'h0000 |=> entry_req
        && entry_level == win_lvl($past(pending_source_bit))
        && vector_addr == `PIS_VEC_TRAP - `PIS_VEC_STEP * 16'(entry_level)
        && stacked_pc == $past(cur_pc) - `PIS_MSG_PC_ADJ)
        else $error("hardware entry wrong");
    a_break_trap: assert property (force_trap == break_hit)
        else $error("break not forcing trap");
    a_entry_pulse: assert property (entry_req |-> $past(instr_done) ##1 !entry_req)
        else $error("entry pulse wrong");
    // Source flags
    a_ext_latch: assert property (!ext_req_n [*6] |-> ext_request_flag)
        else $error("pin request not latched");
    a_wrap_flag: assert property (
        tim_wrap[1] && tim_cnt_next == 16'h0000 |=> counter_wrap_flag[1])
        else $error("wrap flag missing");
    a_spi_rx_flag: assert property (spi_rx_xfer |=> spi_rx_full_flag)
        else $error("spi receive flag missing");
    a_uart_tx_flag: assert property (uart_tx_handoff |=> uart_flags[0])
        else $error("uart tx flag missing");
    a_group_gate: assert property (
        pending_source_bit[2] == (chan_event_flag[0] && chan_event_int_en[0]))
        else $error("group request wrong");

    c_trap: cover property (instr_done && soft_trap_instr ##1 entry_req);
    c_lowest: cover property (entry_req && entry_level == 5'h10);
    c_masked: cover property (instr_done && global_mask && pending_source_bit != 16'h0000);
endmodule : pis_core_sva
`default_nettype wire

// *** pis_cpu_model.sv ***
// Core-side model: instruction completion and global mask
`timescale 1ns/10ps
`default_nettype none
module pis_cpu_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic trp,
    input wire logic msk,
    input wire pis_pkg::pis_addr_t pc,
    input wire logic entry_req,
    output logic instr_done,
    output logic soft_trap_instr,
    output logic global_mask,
    output pis_pkg::pis_addr_t cur_pc
);
    import pis_pkg::*;
    // One completion per request, trap flag rides along
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_done <= 1'h0;
            soft_trap_instr <= 1'h0;
            cur_pc <= 16'h0000;
        end else begin
            instr_done <= go;
            soft_trap_instr <= go && trp;
            cur_pc <= go ? pc : cur_pc;
        end
    end
    // Entry sets the mask, as a real core does
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            global_mask <= 1'h1;
        end else if (go) begin
            global_mask <= msk;
        end else if (entry_req) begin
            global_mask <= 1'h1;
        end
    end
endmodule : pis_cpu_model
`default_nettype wire

// *** prioritized_interrupt_sources_tb.sv ***
// Self-checking bench for the interrupt source block
`timescale 1ns/10ps
`default_nettype none
`include "pis_params.svh"
module prioritized_interrupt_sources_tb;
    import pis_pkg::*;
    // Expected level for each stimulus bit, zero means no request
    localparam int LVL [26] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
                                11, 11, 11, 9, 9, 13, 12, 0, 0};
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic go = 1'h0;
    logic trp = 1'h0;
    logic msk = 1'h0;
    logic en = 1'h1;
    logic clr = 1'h0;
    logic [25:0] ev = '0;
    pis_addr_t pcv = 16'h0000;
    logic instr_done, soft_trap_instr, global_mask, entry_req, stack_upper_index, force_trap;
    pis_addr_t cur_pc, vector_addr, stacked_pc;
    pis_level_t entry_level;
    logic [15:0] pending_source_bit;
    logic ext_request_flag, clock_loss_flag, spi_rx_full_flag, spi_tx_empty_flag;
    logic spi_mode_fault_flag, spi_overflow_flag;
    logic [1:0] counter_wrap_flag;
    logic [3:0] chan_event_flag;
    logic [7:0] uart_flags;
    int num_errors = 0;
    int tests_run = 0;

    // Clock
    always #10 clk = ~clk;

    pis_cpu_model cpu (.clk(clk), .rstn(rstn), .go(go), .trp(trp), .msk(msk), .pc(pcv),
        .entry_req(entry_req), .instr_done(instr_done), .soft_trap_instr(soft_trap_instr),
        .global_mask(global_mask), .cur_pc(cur_pc));

    // Each stimulus bit drives one source event; one bit per source keeps tests table-driven
    pis_core uut (.clk(clk), .rstn(rstn), .instr_done(instr_done), .global_mask(global_mask),
        .soft_trap_instr(soft_trap_instr), .break_hit(ev[25]), .cur_pc(cur_pc),
        .entry_req(entry_req), .vector_addr(vector_addr), .stacked_pc(stacked_pc),
        .stack_upper_index(stack_upper_index), .force_trap(force_trap),
        .entry_level(entry_level), .ext_req_n(!ev[1]), .ext_request_mask(!en),
        .ext_clear(clr), .clock_monitor_on(en), .sel_clock_active(!ev[2]),
        .clock_loss_int_en(en), .clock_loss_clear(clr), .tim_wrap({ev[8], ev[5] | ev[24]}),
        .tim_cnt_next({15'h0000, ev[24]}), .counter_wrap_int_en({2{en}}),
        .counter_wrap_clear({2{clr}}), .chan_event({ev[7], ev[6], ev[4], ev[3]}),
        .chan_event_int_en({4{en}}), .chan_event_clear({4{clr}}),
        .spi_rx_xfer(ev[9] | ev[20]), .spi_tx_xfer(ev[10]), .spi_is_master(ev[21]),
        .spi_busy(1'h0), .spi_sel_n(!ev[21]), .spi_mode_fault_check_en(ev[21]),
        .spi_rx_unread(ev[20]), .spi_rx_int_en(en), .spi_tx_int_en(en),
        .spi_error_int_en(en), .spi_clear({4{clr}}), .uart_tx_handoff(ev[13]),
        .uart_tx_shift_empty(ev[22]), .uart_tx_data_empty(ev[22]), .uart_break_idle_gen(1'h0),
        .uart_rx_handoff(ev[12] | ev[19]), .uart_rx_unread(ev[19]),
        .uart_rx_bit_valid(ev[23]), .uart_rx_bit(ev[23]), .uart_idle_long(1'h0),
        .uart_noise_seen(ev[17]), .uart_stop_sample(ev[18]), .uart_parity_bad(ev[11]),
        .uart_tx_empty_en(en), .uart_tx_done_en(en), .uart_rx_full_en(en),
        .uart_idle_int_en(en), .uart_overrun_en(en), .uart_noise_en(en),
        .uart_framing_int_en(en), .uart_parity_int_en(en), .uart_clear({8{clr}}),
        .other_req(ev[16:14]), .pending_source_bit(pending_source_bit),
        .ext_request_flag(ext_request_flag), .clock_loss_flag(clock_loss_flag),
        .counter_wrap_flag(counter_wrap_flag), .chan_event_flag(chan_event_flag),
        .spi_rx_full_flag(spi_rx_full_flag), .spi_tx_empty_flag(spi_tx_empty_flag),
        .spi_mode_fault_flag(spi_mode_fault_flag), .spi_overflow_flag(spi_overflow_flag),
        .uart_flags(uart_flags));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // Hold events long enough for pin synchronisers and the ten-ones idle count
    task automatic fire(input logic [25:0] v, input logic e);
        @(posedge clk);
        ev <= v;
        en <= e;
        repeat (12) @(posedge clk);
        chk(16'(force_trap), 16'(v[25]), "force_trap");
    endtask : fire

    // One instruction completes; entry expected or not
    task automatic step(input logic t, input logic m, input pis_addr_t pc, input int lv,
                        input logic ent);
        @(posedge clk);
        go <= 1'h1;
        trp <= t;
        msk <= m;
        pcv <= pc;
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        #1;
        chk(16'(entry_req), 16'(ent), "entry_req");
        if (ent) begin
            chk(16'(entry_level), 16'(lv), "entry_level");
            chk(vector_addr, `PIS_VEC_TRAP - 16'(2 * lv), "vector_addr");
            // A break point runs the trap, so it stacks the plain counter too
            chk(stacked_pc, t || ev[25] ? pc : pc - 16'h0001, "stacked_pc");
            chk(16'(stack_upper_index), 16'h0000, "upper_index");
        end
        @(posedge clk);
    endtask : step

    // Release events, let pins settle, then clear every flag
    task automatic clear();
        ev <= '0;
        repeat (5) @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        @(posedge clk);
        #1;
        chk(pending_source_bit, 16'h0000, "pending");
    endtask : clear

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        #1;
        chk(vector_addr, `PIS_VEC_RESET, "reset vector");
        for (int b = 1; b < 25; b++) begin
            fire(26'h000_0001 << b, 1'h1);
            // Overrun handoff also fills the receive register, so level 12 is pending too
            chk(pending_source_bit, 16'(LVL[b] ? 1 << (LVL[b] - 1) : 0)
                | (16'(b == 19) << 11), "pending");
            step(1'h0, 1'h0, 16'h1000 + 16'(b), LVL[b], LVL[b] != 0);
            clear();
        end
        // Break point forces a trap
        fire(26'h200_0000, 1'h1);
        step(1'h0, 1'h0, 16'h2400, 0, 1'h1);
        clear();
        // Mask blocks hardware but not the trap; hardware enters once the mask is cleared
        fire(26'h000_0020, 1'h1);
        step(1'h0, 1'h1, 16'h2000, 0, 1'h0);
        step(1'h1, 1'h1, 16'h2100, 0, 1'h1);
        step(1'h0, 1'h0, 16'h2200, 5, 1'h1);
        clear();
        // Two groups pending: lower level wins
        fire(26'h000_2008, 1'h1);
        step(1'h0, 1'h0, 16'h3000, 3, 1'h1);
        clear();
        // Disabled flag still latches and requests once enabled
        fire(26'h000_0010, 1'h0);
        chk(pending_source_bit, 16'h0000, "pending");
        en <= 1'h1;
        @(posedge clk);
        #1;
        chk(pending_source_bit, 16'h0008, "pending");
        step(1'h0, 1'h0, 16'h4000, 4, 1'h1);
        clear();
        // Reset in mid-run restores the reset vector
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        #1;
        chk(vector_addr, `PIS_VEC_RESET, "reset vector");
        test_done();
    end

    // Watchdog, about thirty times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule : prioritized_interrupt_sources_tb

bind pis_core pis_core_sva chk_i (.clk(clk), .rstn(rstn), .instr_done(instr_done),
    .global_mask(global_mask), .soft_trap_instr(soft_trap_instr), .break_hit(break_hit),
    .cur_pc(cur_pc), .entry_req(entry_req), .vector_addr(vector_addr),
    .stacked_pc(stacked_pc), .stack_upper_index(stack_upper_index), .force_trap(force_trap),
    .entry_level(entry_level), .ext_req_n(ext_req_n), .tim_wrap(tim_wrap),
    .tim_cnt_next(tim_cnt_next), .chan_event_int_en(chan_event_int_en),
    .spi_rx_xfer(spi_rx_xfer), .uart_tx_handoff(uart_tx_handoff),
    .pending_source_bit(pending_source_bit), .ext_request_flag(ext_request_flag),
    .counter_wrap_flag(counter_wrap_flag), .chan_event_flag(chan_event_flag),
    .spi_rx_full_flag(spi_rx_full_flag), .uart_flags(uart_flags));
`default_nettype wire
